/* File: src/stmr_pkg.sv */
// Package: register map, field layout and modes of the standard timer unit
package stmr_pkg;
  localparam int CNT_W = 10;
  localparam logic [2:0] ADDR_CTRL_FIRST = 3'h0;
  localparam logic [2:0] ADDR_CTRL_SECOND = 3'h1;
  localparam logic [2:0] ADDR_CNT_LOW = 3'h2;
  localparam logic [2:0] ADDR_CNT_HIGH = 3'h3;
  localparam logic [2:0] ADDR_CMPA_LOW = 3'h4;
  localparam logic [2:0] ADDR_CMPA_HIGH = 3'h5;
  localparam logic [2:0] ADDR_PFS_LOW = 3'h6;
  localparam logic [2:0] ADDR_PFS_HIGH = 3'h7;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] PFS_LOW_MASK = 8'h3f;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;
  localparam logic [1:0] FUNC_ALT_B = 2'h2;
  localparam logic [1:0] FUNC_ALT_C = 2'h3;
  localparam logic [2:0] CLK_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CLK_SYS = 3'h1;
  localparam logic [2:0] CLK_HIGH_DIV16 = 3'h2;
  localparam logic [2:0] CLK_HIGH_DIV64 = 3'h3;
  localparam logic [2:0] CLK_EXT_RISE = 3'h6;
  localparam logic [2:0] CLK_EXT_FALL = 3'h7;
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [1:0] CAP_RISE = 2'h0;
  localparam logic [1:0] CAP_FALL = 2'h1;
  localparam logic [1:0] CAP_BOTH = 2'h2;
  localparam logic [1:0] PWM_FORCE_INACT = 2'h0;
  localparam logic [1:0] PWM_FORCE_ACT = 2'h1;
  localparam logic [1:0] PWM_RUN = 2'h2;
  localparam logic [1:0] PWM_SINGLE = 2'h3;
  localparam int DIV16_W = 4;
  localparam int DIV64_W = 6;
  typedef struct packed {
    logic pause;
    logic [2:0] clockSelect;
    logic timerOn;
    logic [2:0] comparePValue;
  } stmr_ctrl_first_type;
  typedef struct packed {
    logic [1:0] opMode;
    logic [1:0] pinActionSelect;
    logic outInitial;
    logic outPolarity;
    logic dutyPeriodSwap;
    logic clearOnA;
  } stmr_ctrl_second_type;
  typedef struct packed {
    logic timerOutEn;
    logic timerOutInvEn;
    logic [5:0] lcdSegmentEn;
  } stmr_pin_route_type;
  typedef enum logic [2:0] {
    SP_IDLE = 3'b001,
    SP_ARMED = 3'b010,
    SP_PULSE = 3'b100
  } stmr_single_state_type;
endpackage

/* File: src/stmr_edge_sync.sv */
// Two-stage synchroniser plus a third stage for rising and falling edge pulses
`timescale 1ns/1ns
module stmr_edge_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);
  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge clock) begin
    if (rst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_comb begin
    level = stage2;
    rise = stage2 & ~stage3;
    fall = ~stage2 & stage3;
  end
endmodule

/* File: src/stmr_timer_core.sv */
// Standard timer unit: counter, comparators, output pins and pin routing
//
// Operation
// - Counter compared against comparators, match interrupts
// - Match may clear counter, change output
// - Separate interrupts for comparators A and P
// - Count clock chosen by select field
// - External pin counts rising or falling edge
// - Single pulse triggered by external clock pin
// - Capture edge rising, falling or both
// - Inverted output is complement of main
// - Compare match forces output high/low/toggle
// - Edge aligned PWM, duty or period adjustable
// - Compare A low write loads buffer only
// - High write updates, transfers buffer low
// - High read copies low into buffer
// - Low read returns holding buffer
// - PA4 field code 11 gives timer out
// - PA5 field: 10 inverted out, 11 LCD
// - PA1 field: 11 LCD, else shared IO
// - PA0/2/6/7 fields: 11 LCD segment
// - First select register upper bits read zero
// - Ten bit up counter
// - Counter clears on overflow, match, switch-on
`timescale 1ns/1ns
module stmr_timer_core
  import stmr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  input wire logic extCountClockPin,
  input wire logic captureInPin,
  input wire logic subClockTick,
  output logic timerOutPin,
  output logic timerOutInvPin,
  output logic compareAIrq,
  output logic comparePIrq,
  output stmr_pin_route_type pinRoute,
  output logic pa1SharedIoSel
);
  stmr_ctrl_first_type ctrlFirst;
  stmr_ctrl_second_type ctrlSecond;
  logic [CNT_W-1:0] counter;
  logic [CNT_W-1:0] compareA;
  logic [7:0] holdBuffer;
  logic [7:0] pinSelLow;
  logic [7:0] pinSelHigh;
  logic [DIV64_W-1:0] prescale;
  logic timerOnDly;
  logic outState;
  logic extLevel;
  logic extRise;
  logic extFall;
  logic capLevel;
  logic capRise;
  logic capFall;
  logic countTick;
  logic matchA;
  logic matchP;
  logic overflow;
  logic switchOn;
  logic capEvent;
  logic spTrigger;
  stmr_single_state_type spState;
  logic [CNT_W-1:0] periodLimit;
  logic pwmLevel;
  logic next_outState;
  logic countAdvance;
  logic clearOnMatchA;
  logic clearOnMatchP;
  logic [CNT_W-1:0] next_counter;

  stmr_edge_sync extSync (
    .clock(clock),
    .rst(rst),
    .pinIn(extCountClockPin),
    .level(extLevel),
    .rise(extRise),
    .fall(extFall)
  );

  stmr_edge_sync capSync (
    .clock(clock),
    .rst(rst),
    .pinIn(captureInPin),
    .level(capLevel),
    .rise(capRise),
    .fall(capFall)
  );

  // Prescaler for internal clock ratios
  always_ff @(posedge clock) begin
    if (rst) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  always_comb begin
    case (ctrlFirst.clockSelect)
      CLK_SYS_DIV4: countTick = (prescale[1:0] == 2'h3);
      CLK_SYS: countTick = 1'b1;
      CLK_HIGH_DIV16: countTick = (prescale[DIV16_W-1:0] == 4'hf);
      CLK_HIGH_DIV64: countTick = (prescale == 6'h3f);
      CLK_EXT_RISE: countTick = extRise;
      CLK_EXT_FALL: countTick = extFall;
      default: countTick = subClockTick;
    endcase
  end

  assign switchOn = ctrlFirst.timerOn & ~timerOnDly;
  assign overflow = (counter == CNT_MAX);
  // Last count of a comparator P period; zero means the full range
  assign periodLimit = (ctrlFirst.comparePValue == 3'h0) ? CNT_MAX
                       : {ctrlFirst.comparePValue - 3'h1, 7'h7f};
  assign countAdvance = ctrlFirst.timerOn & ~ctrlFirst.pause & countTick & ~switchOn & (spState != SP_ARMED);
  assign clearOnMatchA = ctrlSecond.clearOnA & (counter == compareA);
  assign clearOnMatchP = ~ctrlSecond.clearOnA & (ctrlFirst.comparePValue != 3'h0) & (counter == periodLimit);
  // Match A flags the tick on which the counter reaches compare A, match P the tick on which it leaves periodLimit while comparator P is nonzero
  assign matchA = countAdvance & (next_counter == compareA);
  assign matchP = countAdvance & (ctrlFirst.comparePValue != 3'h0) & (counter == periodLimit);
  assign capEvent = (ctrlSecond.pinActionSelect == CAP_RISE & capRise)
                  | (ctrlSecond.pinActionSelect == CAP_FALL & capFall)
                  | (ctrlSecond.pinActionSelect == CAP_BOTH & (capRise | capFall));
  assign spTrigger = (ctrlFirst.clockSelect == CLK_EXT_FALL) ? extFall : extRise;

  always_ff @(posedge clock) begin
    if (rst) begin
      timerOnDly <= 1'b0;
    end else begin
      timerOnDly <= ctrlFirst.timerOn;
    end
  end

  // Next count: switch-on clear, wrap on overflow or match, else step
  always_comb begin
    next_counter = counter;
    if (switchOn) begin
      next_counter = CNT_ZERO;
    end else if (countAdvance) begin
      if (overflow | clearOnMatchA | clearOnMatchP) begin
        next_counter = CNT_ZERO;
      end else begin
        next_counter = counter + 1'b1;
      end
    end
  end

  // Counter
  always_ff @(posedge clock) begin
    if (rst) begin
      counter <= CNT_ZERO;
    end else begin
      counter <= next_counter;
    end
  end

  // Interrupt pulses, one block for each comparator
  always_ff @(posedge clock) begin
    if (rst) begin
      compareAIrq <= 1'b0;
    end else begin
      compareAIrq <= matchA | (ctrlSecond.opMode == MODE_CAPTURE & ctrlFirst.timerOn & capEvent);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      comparePIrq <= 1'b0;
    end else begin
      comparePIrq <= matchP;
    end
  end

  // Single pulse sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      spState <= SP_IDLE;
    end else begin
      case (spState)
        SP_IDLE: begin
          if (ctrlFirst.timerOn & ctrlSecond.opMode == MODE_PWM & ctrlSecond.pinActionSelect == PWM_SINGLE) begin
            spState <= SP_ARMED;
          end
        end
        SP_ARMED: begin
          if (~ctrlFirst.timerOn) begin
            spState <= SP_IDLE;
          end else if (spTrigger) begin
            spState <= SP_PULSE;
          end
        end
        SP_PULSE: begin
          if (~ctrlFirst.timerOn | (matchA & ~ctrlFirst.pause)) begin
            spState <= SP_IDLE;
          end
        end
        default: spState <= SP_IDLE;
      endcase
    end
  end

  // PWM: active from period start until compare A, swapped when requested
  assign pwmLevel = ctrlSecond.dutyPeriodSwap ? (counter < {ctrlFirst.comparePValue, 7'h00})
                                              : (counter < compareA);

  always_comb begin
    next_outState = outState;
    if (switchOn) begin
      next_outState = ctrlSecond.outInitial;
    end else if (ctrlFirst.timerOn) begin
      case (ctrlSecond.opMode)
        MODE_COMPARE: begin
          if (matchA) begin
            case (ctrlSecond.pinActionSelect)
              ACT_LOW: next_outState = 1'b0;
              ACT_HIGH: next_outState = 1'b1;
              ACT_TOGGLE: next_outState = ~outState;
              default: next_outState = outState;
            endcase
          end
        end
        MODE_PWM: begin
          case (ctrlSecond.pinActionSelect)
            PWM_FORCE_INACT: next_outState = 1'b0;
            PWM_FORCE_ACT: next_outState = 1'b1;
            PWM_RUN: next_outState = pwmLevel;
            default: next_outState = (spState == SP_PULSE);
          endcase
        end
        default: next_outState = outState;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      outState <= 1'b0;
    end else begin
      outState <= next_outState;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      timerOutPin <= 1'b0;
      timerOutInvPin <= 1'b1;
    end else begin
      timerOutPin <= next_outState ^ ctrlSecond.outPolarity;
      timerOutInvPin <= ~(next_outState ^ ctrlSecond.outPolarity);
    end
  end

  // Register writes
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrlFirst <= REG_RESET;
      ctrlSecond <= REG_RESET;
      pinSelLow <= REG_RESET;
      pinSelHigh <= REG_RESET;
    end else if (regWrite) begin
      case (regAddr)
        ADDR_CTRL_FIRST: ctrlFirst <= regWriteData;
        ADDR_CTRL_SECOND: ctrlSecond <= regWriteData;
        ADDR_PFS_LOW: pinSelLow <= regWriteData & PFS_LOW_MASK;
        ADDR_PFS_HIGH: pinSelHigh <= regWriteData;
        default: pinSelHigh <= pinSelHigh;
      endcase
    end
  end

  // Compare A takes both bytes on the high byte write
  always_ff @(posedge clock) begin
    if (rst) begin
      compareA <= CNT_ZERO;
    end else if (regWrite & regAddr == ADDR_CMPA_HIGH) begin
      compareA <= {regWriteData[1:0], holdBuffer};
    end
  end

  // Holding buffer, only touched by low write or high read
  always_ff @(posedge clock) begin
    if (rst) begin
      holdBuffer <= REG_RESET;
    end else if (regWrite & regAddr == ADDR_CMPA_LOW) begin
      holdBuffer <= regWriteData;
    end else if (regRead & regAddr == ADDR_CNT_HIGH) begin
      holdBuffer <= counter[7:0];
    end else if (regRead & regAddr == ADDR_CMPA_HIGH) begin
      holdBuffer <= compareA[7:0];
    end else begin
      holdBuffer <= holdBuffer;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      regReadData <= REG_RESET;
    end else if (regRead) begin
      case (regAddr)
        ADDR_CTRL_FIRST: regReadData <= ctrlFirst;
        ADDR_CTRL_SECOND: regReadData <= ctrlSecond;
        ADDR_CNT_LOW: regReadData <= holdBuffer;
        ADDR_CNT_HIGH: regReadData <= {6'h00, counter[CNT_W-1:8]};
        ADDR_CMPA_LOW: regReadData <= holdBuffer;
        ADDR_CMPA_HIGH: regReadData <= {6'h00, compareA[CNT_W-1:8]};
        ADDR_PFS_LOW: regReadData <= pinSelLow & PFS_LOW_MASK;
        default: regReadData <= pinSelHigh;
      endcase
    end else begin
      regReadData <= REG_RESET;
    end
  end

  // Pin function routing
  always_ff @(posedge clock) begin
    if (rst) begin
      pinRoute <= '0;
    end else begin
      pinRoute.timerOutEn <= (pinSelHigh[1:0] == FUNC_ALT_C);
      pinRoute.timerOutInvEn <= (pinSelHigh[3:2] == FUNC_ALT_B);
      pinRoute.lcdSegmentEn[0] <= (pinSelLow[1:0] == FUNC_ALT_C);
      pinRoute.lcdSegmentEn[1] <= (pinSelLow[3:2] == FUNC_ALT_C);
      pinRoute.lcdSegmentEn[2] <= (pinSelLow[5:4] == FUNC_ALT_C);
      pinRoute.lcdSegmentEn[3] <= (pinSelHigh[3:2] == FUNC_ALT_C);
      pinRoute.lcdSegmentEn[4] <= (pinSelHigh[5:4] == FUNC_ALT_C);
      pinRoute.lcdSegmentEn[5] <= (pinSelHigh[7:6] == FUNC_ALT_C);
    end
  end

  // Shared input path of the count clock pin stays open unless segment mode
  always_ff @(posedge clock) begin
    if (rst) begin
      pa1SharedIoSel <= 1'b1;
    end else begin
      pa1SharedIoSel <= (pinSelLow[3:2] != FUNC_ALT_C);
    end
  end

  logic unusedLevels;
  assign unusedLevels = extLevel ^ capLevel;
endmodule

/* File: test/stmr_pin_model.sv */
// Pin-side model: external count clock, capture input and sub clock ticks
`timescale 1ns/1ns
module stmr_pin_model (
  input wire logic clock,
  input wire logic extReq,
  input wire logic capReq,
  output logic extCountClockPin,
  output logic captureInPin,
  output logic subClockTick
);
  logic [3:0] extCnt = 4'h0;
  logic [2:0] subCnt = 3'h0;
  logic capLvl = 1'b0;
  logic tick = 1'b0;
  // Slow pulse: eight cycles high, then low until the next request
  always_ff @(posedge clock) begin
    if (extReq) begin
      extCnt <= 4'hf;
    end else if (extCnt != 4'h0) begin
      extCnt <= extCnt - 4'h1;
    end
  end
  always_ff @(posedge clock) begin
    if (capReq) begin
      capLvl <= !capLvl;
    end
  end
  always_ff @(posedge clock) begin
    subCnt <= subCnt + 3'h1;
    tick <= subCnt == 3'h7;
  end
  assign extCountClockPin = extCnt[3];
  assign captureInPin = capLvl;
  assign subClockTick = tick;
endmodule

/* File: test/stmr_timer_core_chk.sv */
// Concurrent checks on the timer core ports
`timescale 1ns/1ns
module stmr_timer_core_chk
  import stmr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regReadData,
  input wire logic timerOutPin,
  input wire logic timerOutInvPin,
  input wire logic compareAIrq,
  input wire stmr_pin_route_type pinRoute
);
  logic [7:0] pfsLo, pfsHi, bufA;
  logic [9:0] cmpA;
  logic [7:0] expRoute;
  always_ff @(posedge clock) begin
    if (rst) begin
      pfsLo <= REG_RESET;
      pfsHi <= REG_RESET;
      bufA <= REG_RESET;
      cmpA <= CNT_ZERO;
    end else if (regWrite) begin
      case (regAddr)
        ADDR_PFS_LOW: pfsLo <= regWriteData & PFS_LOW_MASK;
        ADDR_PFS_HIGH: pfsHi <= regWriteData;
        ADDR_CMPA_LOW: bufA <= regWriteData;
        ADDR_CMPA_HIGH: cmpA <= {regWriteData[1:0], bufA};
        default: ;
      endcase
    end
  end
  function automatic logic alt(input logic [1:0] f);
    return f == FUNC_ALT_C;
  endfunction
  assign expRoute = {alt(pfsHi[1:0]), pfsHi[3:2] == FUNC_ALT_B, alt(pfsHi[7:6]), alt(pfsHi[5:4]),
    alt(pfsHi[3:2]), alt(pfsLo[5:4]), alt(pfsLo[3:2]), alt(pfsLo[1:0])};
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_inv_complement: assert property (timerOutInvPin == !timerOutPin)
    else $error("inverted output not complement");
  a_pa4_route: assert property (!regWrite [*2] |=> pinRoute.timerOutEn == expRoute[7])
    else $error("timer output route wrong");
  a_pa5_route: assert property (!regWrite [*2] |=> pinRoute.timerOutInvEn == expRoute[6])
    else $error("inverted output route wrong");
  a_lcd_route: assert property (!regWrite [*2] |=> pinRoute.lcdSegmentEn == expRoute[5:0])
    else $error("segment route wrong");
  a_pfs_low_read: assert property (regRead && regAddr == ADDR_PFS_LOW |=> regReadData == pfsLo)
    else $error("select low readback wrong");
  a_pfs_high_read: assert property (regRead && regAddr == ADDR_PFS_HIGH |=> regReadData == pfsHi)
    else $error("select high readback wrong");
  a_cmpa_high_read: assert property (regRead && regAddr == ADDR_CMPA_HIGH |=> regReadData[1:0] == cmpA[9:8])
    else $error("compare high read wrong");
  a_cmpa_low_read: assert property (
    regRead && regAddr == ADDR_CMPA_HIGH ##1 regRead && regAddr == ADDR_CMPA_LOW |=> regReadData == cmpA[7:0])
    else $error("compare low read wrong");
  c_match_a: cover property (compareAIrq);
  c_pin_rise: cover property ($rose(timerOutPin));
  c_route_on: cover property (pinRoute.timerOutEn);
endmodule
bind stmr_timer_core stmr_timer_core_chk chk (.clock(clock), .rst(rst), .regAddr(regAddr),
  .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
  .timerOutPin(timerOutPin), .timerOutInvPin(timerOutInvPin), .compareAIrq(compareAIrq), .pinRoute(pinRoute));

/* File: test/stmr_timer_core_bench.sv */
// Self-checking bench for the timer core
`timescale 1ns/1ns
module stmr_timer_core_bench;
  import stmr_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWriteData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic extReq = 1'b0;
  logic capReq = 1'b0;
  logic [7:0] regReadData;
  logic extCountClockPin, captureInPin, subClockTick, timerOutPin, timerOutInvPin, compareAIrq, pa1SharedIoSel;
  logic comparePIrq;
  stmr_pin_route_type pinRoute;
  logic [7:0] expQ[$];
  logic rdPend = 1'b0;
  logic [9:0] v;
  int n_fail = 0;
  int checked = 0;
  int seed = 1;
  int t, irqs, hi;
  stmr_timer_core DUT (.clock(clock), .rst(rst), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .extCountClockPin(extCountClockPin),
    .captureInPin(captureInPin), .subClockTick(subClockTick), .timerOutPin(timerOutPin),
    .timerOutInvPin(timerOutInvPin), .compareAIrq(compareAIrq), .comparePIrq(comparePIrq), .pinRoute(pinRoute),
    .pa1SharedIoSel(pa1SharedIoSel));
  stmr_pin_model PINS (.clock(clock), .extReq(extReq), .capReq(capReq), .extCountClockPin(extCountClockPin),
    .captureInPin(captureInPin), .subClockTick(subClockTick));
  always #2 clock = !clock;
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // One bus cycle; for a read, d is the expected data
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite <= w;
    regRead <= !w;
    regAddr <= a;
    regWriteData <= d;
    if (!w) expQ.push_back(d);
  endtask
  task automatic idle(input int n);
    @(posedge clock);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    repeat (n) @(posedge clock);
  endtask
  task automatic waitIrq(output int c);
    c = 0;
    do begin
      @(posedge clock);
      c++;
    end while (compareAIrq !== 1'b1 && c < 200);
  endtask
  task automatic pulse(output int n);
    n = 0;
    extReq <= 1'b1;
    @(posedge clock);
    extReq <= 1'b0;
    repeat (24) begin
      @(posedge clock);
      if (compareAIrq === 1'b1) n++;
    end
  endtask
  always @(posedge clock) begin
    if (rdPend) chk("read data", expQ.pop_front(), regReadData);
    rdPend <= regRead && !rst;
  end
  initial begin
    #100000;
    n_fail++;
    finish_test;
  end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) bus(1'b0, a[2:0], REG_RESET);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_PFS_LOW, {4{i[1:0]}});
      bus(1'b1, ADDR_PFS_HIGH, {4{i[1:0]}});
      bus(1'b0, ADDR_PFS_LOW, {2'b00, {3{i[1:0]}}});
      bus(1'b0, ADDR_PFS_HIGH, {4{i[1:0]}});
      idle(3);
      chk("route", {i == 3, i == 2, {6{i == 3}}}, pinRoute);
      chk("pa1 shared", {7'h0, i != 3}, {7'h0, pa1SharedIoSel});
    end
    repeat (4) begin
      v = 10'($random(seed));
      bus(1'b1, ADDR_CMPA_LOW, v[7:0]);
      bus(1'b1, ADDR_CMPA_HIGH, {6'h0, v[9:8]});
      bus(1'b1, ADDR_CMPA_LOW, ~v[7:0]);
      bus(1'b0, ADDR_CMPA_HIGH, {6'h0, v[9:8]});
      bus(1'b0, ADDR_CMPA_LOW, v[7:0]);
      idle(0);
    end
    bus(1'b1, ADDR_CMPA_LOW, 8'h14);
    bus(1'b1, ADDR_CMPA_HIGH, 8'h00);
    // Output low, high, toggle; low starts from a high initial level
    for (int k = 1; k < 4; k++) begin
      bus(1'b1, ADDR_CTRL_FIRST, {1'b0, CLK_SYS, 1'b0, 3'h0});
      bus(1'b1, ADDR_CTRL_SECOND, {MODE_COMPARE, k[1:0], k == 1, 3'b001});
      bus(1'b1, ADDR_CTRL_FIRST, {1'b0, CLK_SYS, 1'b1, 3'h0});
      idle(0);
      waitIrq(t);
      repeat (2) @(posedge clock);
      chk("out pin", {7'h0, k != 1}, {7'h0, timerOutPin});
      waitIrq(t);
      chk("match period", 8'd19, t[7:0]);
    end
    bus(1'b1, ADDR_CMPA_LOW, 8'h03);
    bus(1'b1, ADDR_CMPA_HIGH, 8'h00);
    for (int k = 6; k < 8; k++) begin
      bus(1'b1, ADDR_CTRL_FIRST, {1'b0, k[2:0], 1'b0, 3'h0});
      bus(1'b1, ADDR_CTRL_FIRST, {1'b0, k[2:0], 1'b1, 3'h0});
      idle(2);
      for (int p = 0; p < 4; p++) begin
        pulse(irqs);
        chk("edge count", {7'h0, p == 2}, 8'(irqs));
      end
    end
    bus(1'b1, ADDR_CMPA_LOW, 8'hff);
    bus(1'b1, ADDR_CMPA_HIGH, 8'h03);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, ADDR_CTRL_FIRST, {1'b0, CLK_SYS, 1'b0, 3'h0});
      bus(1'b1, ADDR_CTRL_SECOND, {MODE_CAPTURE, k[1:0], 4'h0});
      bus(1'b1, ADDR_CTRL_FIRST, {1'b0, CLK_SYS, 1'b1, 3'h0});
      idle(2);
      irqs = 0;
      repeat (2) begin
        capReq <= 1'b1;
        @(posedge clock);
        capReq <= 1'b0;
        repeat (10) begin
          @(posedge clock);
          if (compareAIrq === 1'b1) irqs++;
        end
      end
      chk("capture events", (k == 2) ? 8'h02 : 8'h01, 8'(irqs));
    end
    // Edge aligned PWM: period from comparator P, duty from compare A
    bus(1'b1, ADDR_CMPA_LOW, 8'h40);
    bus(1'b1, ADDR_CMPA_HIGH, 8'h00);
    bus(1'b1, ADDR_CTRL_FIRST, {1'b0, CLK_SYS, 1'b0, 3'h1});
    bus(1'b1, ADDR_CTRL_SECOND, {MODE_PWM, PWM_RUN, 4'h0});
    bus(1'b1, ADDR_CTRL_FIRST, {1'b0, CLK_SYS, 1'b1, 3'h1});
    idle(0);
    t = 0;
    do begin
      @(posedge clock);
      t++;
    end while (comparePIrq !== 1'b1 && t < 400);
    irqs = 0;
    hi = 0;
    repeat (128) begin
      @(posedge clock);
      if (comparePIrq === 1'b1) irqs++;
      if (timerOutPin === 1'b1) hi++;
    end
    chk("period P matches", 8'h01, 8'(irqs));
    chk("pwm high cycles", 8'h40, 8'(hi));
    idle(4);
    finish_test;
  end
endmodule
